/* shared/exec_cfg.svh */
// constants for the arithmetic, logic and branch execution block
`ifndef EXEC_CFG_SVH
`define EXEC_CFG_SVH

`define DATA_W        8
`define PC_W          22
`define ZPTR_W        16
`define OFFS_W        12
`define BITSEL_W      3
`define CYC_W         3

`define FLAG_C        0
`define FLAG_Z        1
`define FLAG_N        2
`define FLAG_V        3
`define FLAG_S        4
`define FLAG_H        5
`define FLAG_T        6
`define FLAG_I        7

`define BYTE_ONES     8'hFF
`define CYC_ALU       3'h1
`define CYC_BR_TAKEN  3'h2
`define CYC_JUMP      3'h2
`define CYC_SKIP_NONE 3'h1
`define CYC_SKIP_ONE  3'h2
`define CYC_SKIP_TWO  3'h3
`define CYC_CALL_DEF  3
`define PC_STEP       22'h000001
`define PC_SKIP_ONE   22'h000002
`define PC_SKIP_TWO   22'h000003

`endif

/* shared/exec_pkg.sv */
// types shared by the execution block and its two helpers
`include "exec_cfg.svh"
package exec_pkg;

    typedef enum logic [4:0] {
        OP_ADD       = 5'h00,
        OP_ADC       = 5'h01,
        OP_SUB       = 5'h02,
        OP_SBC       = 5'h03,
        OP_AND       = 5'h04,
        OP_OR        = 5'h05,
        OP_EOR       = 5'h06,
        OP_CBR       = 5'h07,
        OP_TST       = 5'h08,
        OP_CP        = 5'h09,
        OP_CPC       = 5'h0A,
        OP_COMPARE_SKIP_EQUAL      = 5'h0B,
        OP_SKIP_RB_C = 5'h0C,
        OP_SKIP_RB_S = 5'h0D,
        OP_SKIP_IO_C = 5'h0E,
        OP_SKIP_IO_S = 5'h0F,
        OP_BR_SET    = 5'h10,
        OP_BR_CLR    = 5'h11,
        OP_BR_SGE    = 5'h12,
        OP_BR_SLT    = 5'h13,
        OP_RJMP      = 5'h14,
        OP_RELATIVE_CALL     = 5'h15,
        OP_JUMP_VIA_POINTER      = 5'h16,
        OP_POINTER_CALL     = 5'h17
    } exec_op_t;

    typedef struct packed {
        exec_op_t                 op;
        logic                     use_imm;
        logic [`DATA_W-1:0]       rd_val;
        logic [`DATA_W-1:0]       rr_val;
        logic [`DATA_W-1:0]       imm;
        logic [`BITSEL_W-1:0]     bit_sel;
        logic [`DATA_W-1:0]       io_val;
        logic [`OFFS_W-1:0]       offset;
        logic [`PC_W-1:0]         pc;
        logic [`ZPTR_W-1:0]       z_ptr;
        logic                     next_two_word;
        logic [`DATA_W-1:0]       status_flags_register;
    } exec_req_t;

    typedef struct packed {
        logic                     wr_en;
        logic [`DATA_W-1:0]       wr_data;
        logic                     status_flags_register_we;
        logic [`DATA_W-1:0]       status_flags_register;
        logic                     push_en;
        logic [`PC_W-1:0]         push_addr;
        logic [`PC_W-1:0]         pc_next;
        logic [`CYC_W-1:0]        cycles;
    } exec_res_t;

endpackage

/* rtl/alu8.sv */
// combinational byte datapath with status flag generation
`timescale 1ns/100ps
`include "exec_cfg.svh"
module alu8
(
    input  wire exec_pkg::exec_op_t op,        // decoded operation
    input  wire logic [7:0]         a,         // destination operand
    input  wire logic [7:0]         b,         // source or immediate
    input  wire logic [7:0]         status_flags_register_in,   // current flags
    output logic                    wr_en,     // result goes back
    output logic [7:0]              res,       // result byte
    output logic                    status_flags_register_we,   // flags change
    output logic [7:0]              status_flags_register_out   // new flags
);
    logic [8:0] sum9;
    logic [8:0] dif9;
    logic [4:0] sum_h;
    logic [4:0] dif_h;
    logic       cin;

    // sign is always derived from negative and overflow
    function automatic logic [7:0] set_flags(input logic [7:0] s,
        input logic [7:0] r, input logic c, input logic h,
        input logic v, input logic z, input logic upd_ch);
        logic [7:0] f;
        f = s;
        f[`FLAG_Z] = z;
        f[`FLAG_N] = r[7];
        f[`FLAG_V] = v;
        f[`FLAG_S] = r[7] ^ v;
        if (upd_ch)
        begin
            f[`FLAG_C] = c;
            f[`FLAG_H] = h;
        end
        return f;
    endfunction

    always_comb
    begin
        cin = status_flags_register_in[`FLAG_C] &
              (op == exec_pkg::OP_ADC || op == exec_pkg::OP_SBC ||
               op == exec_pkg::OP_CPC);
        sum9  = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        dif9  = {1'b0, a} - {1'b0, b} - {8'h00, cin};
        sum_h = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
        dif_h = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, cin};
        wr_en    = 1'b0;
        res      = a;
        status_flags_register_we  = 1'b0;
        status_flags_register_out = status_flags_register_in;
        unique case (op)
            exec_pkg::OP_ADD, exec_pkg::OP_ADC:
            begin
                res      = sum9[7:0];
                wr_en    = 1'b1;
                status_flags_register_we  = 1'b1;
                status_flags_register_out = set_flags(status_flags_register_in, sum9[7:0], sum9[8],
                    sum_h[4], (a[7] == b[7]) && (sum9[7] != a[7]),
                    sum9[7:0] == 8'h00, 1'b1);
            end
            exec_pkg::OP_SUB, exec_pkg::OP_SBC,
            exec_pkg::OP_CP, exec_pkg::OP_CPC:
            begin
                // with-carry forms only keep zero if it was already set,
                // so multi-byte compares chain correctly
                res      = dif9[7:0];
                wr_en    = (op == exec_pkg::OP_SUB) ||
                           (op == exec_pkg::OP_SBC);
                status_flags_register_we  = 1'b1;
                status_flags_register_out = set_flags(status_flags_register_in, dif9[7:0], dif9[8],
                    dif_h[4], (a[7] != b[7]) && (dif9[7] != a[7]),
                    (dif9[7:0] == 8'h00) &&
                    (!cin && op != exec_pkg::OP_SBC &&
                     op != exec_pkg::OP_CPC || status_flags_register_in[`FLAG_Z]),
                    1'b1);
            end
            exec_pkg::OP_AND, exec_pkg::OP_OR, exec_pkg::OP_EOR,
            exec_pkg::OP_CBR, exec_pkg::OP_TST:
            begin
                unique case (op)
                    exec_pkg::OP_AND: res = a & b;
                    exec_pkg::OP_OR:  res = a | b;
                    exec_pkg::OP_EOR: res = a ^ b;
                    exec_pkg::OP_CBR: res = a & (`BYTE_ONES - b);
                    default:          res = a & a;
                endcase
                wr_en    = (op != exec_pkg::OP_TST);
                status_flags_register_we  = 1'b1;
                status_flags_register_out = set_flags(status_flags_register_in, res, 1'b0, 1'b0, 1'b0,
                    res == 8'h00, 1'b0);
            end
            default:
            begin
                wr_en    = 1'b0;
                status_flags_register_we  = 1'b0;
            end
        endcase
    end
endmodule

/* rtl/branch_eval.sv */
// program counter, skip and call decision for one request
`timescale 1ns/100ps
`include "exec_cfg.svh"
module branch_eval
#(
    parameter int CALL_CYCLES = `CYC_CALL_DEF
)
(
    input  wire exec_pkg::exec_req_t req,        // request to judge
    output logic [`PC_W-1:0]         pc_next,    // new program counter
    output logic [`CYC_W-1:0]        cycles,     // execution cycles
    output logic                     push_en,    // return address pushed
    output logic [`PC_W-1:0]         push_addr   // return address
);
    logic [`PC_W-1:0] pc_rel;
    logic [`PC_W-1:0] pc_ptr;
    logic [`PC_W-1:0] pc_inc;
    logic             skip;
    logic             taken;
    logic [7:0]       s;

    always_comb
    begin
        s      = req.status_flags_register;
        pc_inc = req.pc + `PC_STEP;
        pc_rel = req.pc + {{(`PC_W-`OFFS_W){req.offset[`OFFS_W-1]}},
                           req.offset} + `PC_STEP;
        pc_ptr = {{(`PC_W-`ZPTR_W){1'b0}}, req.z_ptr};
        skip   = 1'b0;
        taken  = 1'b0;
        unique case (req.op)
            exec_pkg::OP_COMPARE_SKIP_EQUAL:
                skip = (req.rd_val == req.rr_val);
            exec_pkg::OP_SKIP_RB_C:
                skip = !req.rr_val[req.bit_sel];
            exec_pkg::OP_SKIP_RB_S:
                skip = req.rr_val[req.bit_sel];
            exec_pkg::OP_SKIP_IO_C:
                skip = !req.io_val[req.bit_sel];
            exec_pkg::OP_SKIP_IO_S:
                skip = req.io_val[req.bit_sel];
            // aliases for carry, half-carry, T, overflow and interrupt
            // arrive here with their fixed bit select
            exec_pkg::OP_BR_SET:
                taken = s[req.bit_sel];
            exec_pkg::OP_BR_CLR:
                taken = !s[req.bit_sel];
            exec_pkg::OP_BR_SGE:
                taken = !(s[`FLAG_N] ^ s[`FLAG_V]);
            exec_pkg::OP_BR_SLT:
                taken = s[`FLAG_N] ^ s[`FLAG_V];
            default:
                taken = 1'b0;
        endcase
        push_en   = (req.op == exec_pkg::OP_RELATIVE_CALL) ||
                    (req.op == exec_pkg::OP_POINTER_CALL);
        push_addr = pc_inc;
        pc_next   = pc_inc;
        cycles    = `CYC_ALU;
        unique case (req.op)
            exec_pkg::OP_RJMP, exec_pkg::OP_RELATIVE_CALL:
            begin
                pc_next = pc_rel;
                cycles  = (req.op == exec_pkg::OP_RELATIVE_CALL) ?
                          `CYC_W'(CALL_CYCLES) : `CYC_JUMP;
            end
            exec_pkg::OP_JUMP_VIA_POINTER, exec_pkg::OP_POINTER_CALL:
            begin
                pc_next = pc_ptr;
                cycles  = (req.op == exec_pkg::OP_POINTER_CALL) ?
                          `CYC_W'(CALL_CYCLES) : `CYC_JUMP;
            end
            exec_pkg::OP_COMPARE_SKIP_EQUAL, exec_pkg::OP_SKIP_RB_C, exec_pkg::OP_SKIP_RB_S,
            exec_pkg::OP_SKIP_IO_C, exec_pkg::OP_SKIP_IO_S:
            begin
                if (skip && req.next_two_word)
                begin
                    pc_next = req.pc + `PC_SKIP_TWO;
                    cycles  = `CYC_SKIP_TWO;
                end
                else if (skip)
                begin
                    pc_next = req.pc + `PC_SKIP_ONE;
                    cycles  = `CYC_SKIP_ONE;
                end
                else
                    cycles  = `CYC_SKIP_NONE;
            end
            exec_pkg::OP_BR_SET, exec_pkg::OP_BR_CLR,
            exec_pkg::OP_BR_SGE, exec_pkg::OP_BR_SLT:
            begin
                pc_next = taken ? pc_rel : pc_inc;
                cycles  = taken ? `CYC_BR_TAKEN : `CYC_ALU;
            end
            default:
                cycles  = `CYC_ALU;
        endcase
    end
endmodule

/* rtl/arith_logic_branch_exec.sv */
// execution stage for arithmetic, logic, compare, skip, jump and branch
`timescale 1ns/100ps
`include "exec_cfg.svh"
module arith_logic_branch_exec
#(
    parameter int CALL_CYCLES = `CYC_CALL_DEF
)
(
    input  wire logic                ref_clk,    // core clock
    input  wire logic                nrst,       // async reset, low
    input  wire logic                ce,         // clock enable
    input  wire logic                req_valid,  // fetch offers request
    input  wire exec_pkg::exec_req_t req,        // decoded request
    output logic                     ready,      // request can be taken
    output logic                     done,       // last cycle pulse
    output logic                     wr_en,      // write destination
    output logic [`DATA_W-1:0]       wr_data,    // destination value
    output logic                     status_flags_register_we,    // flags write
    output logic [`DATA_W-1:0]       status_flags_register_out,   // new flags
    output logic                     pc_we,      // program counter load
    output logic [`PC_W-1:0]         pc_next,    // new program counter
    output logic                     push_en,    // push return address
    output logic [`PC_W-1:0]         push_addr   // return address
);
    // a call can only last three or four cycles
    if (CALL_CYCLES < 3 || CALL_CYCLES > 4)
        $error("CALL_CYCLES must be 3 or 4");

    typedef enum logic [1:0] {
        S_IDLE = 2'b01,
        S_WAIT = 2'b10
    } exec_state_t;

    exec_state_t         state;
    exec_pkg::exec_res_t pend;
    exec_pkg::exec_res_t now_res;
    logic [`CYC_W-1:0]   remain;
    logic                accept;
    logic                finish;

    alu8 u_alu
    (
        .op       (req.op),
        .a        (req.rd_val),
        .b        (req.use_imm ? req.imm : req.rr_val),
        .status_flags_register_in  (req.status_flags_register),
        .wr_en    (now_res.wr_en),
        .res      (now_res.wr_data),
        .status_flags_register_we  (now_res.status_flags_register_we),
        .status_flags_register_out (now_res.status_flags_register)
    );

    branch_eval #(.CALL_CYCLES(CALL_CYCLES)) u_br
    (
        .req       (req),
        .pc_next   (now_res.pc_next),
        .cycles    (now_res.cycles),
        .push_en   (now_res.push_en),
        .push_addr (now_res.push_addr)
    );

    assign accept = ce && ready && req_valid;
    assign finish = ce && (state == S_WAIT) && (remain == `CYC_W'(1));

    // state and cycle counter
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state  <= S_IDLE;
            remain <= '0;
            ready  <= 1'b1;
        end
        else if (ce)
        begin
            unique case (state)
                S_IDLE:
                begin
                    if (accept && now_res.cycles != `CYC_ALU)
                    begin
                        state  <= S_WAIT;
                        remain <= now_res.cycles - `CYC_W'(1);
                        ready  <= 1'b0;
                    end
                end
                S_WAIT:
                begin
                    remain <= remain - `CYC_W'(1);
                    if (remain == `CYC_W'(1))
                    begin
                        state <= S_IDLE;
                        ready <= 1'b1;
                    end
                end
            endcase
        end
    end

    // result held while a multi-cycle instruction runs
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
            pend <= '0;
        else if (accept)
            pend <= now_res;
    end

    // outputs: pulses last one cycle, data holds until the next result
    always_ff @(posedge ref_clk or negedge nrst)
    begin
        if (!nrst)
        begin
            done      <= 1'b0;
            wr_en     <= 1'b0;
            wr_data   <= '0;
            status_flags_register_we   <= 1'b0;
            status_flags_register_out  <= '0;
            pc_we     <= 1'b0;
            pc_next   <= '0;
            push_en   <= 1'b0;
            push_addr <= '0;
        end
        else if (ce)
        begin
            if (accept && now_res.cycles == `CYC_ALU)
            begin
                done      <= 1'b1;
                wr_en     <= now_res.wr_en;
                wr_data   <= now_res.wr_data;
                status_flags_register_we   <= now_res.status_flags_register_we;
                status_flags_register_out  <= now_res.status_flags_register;
                pc_we     <= 1'b1;
                pc_next   <= now_res.pc_next;
                push_en   <= 1'b0;
                push_addr <= now_res.push_addr;
            end
            else if (finish)
            begin
                // flags never change on jumps, skips and branches
                done      <= 1'b1;
                wr_en     <= 1'b0;
                status_flags_register_we   <= 1'b0;
                status_flags_register_out  <= pend.status_flags_register;
                pc_we     <= 1'b1;
                pc_next   <= pend.pc_next;
                push_en   <= pend.push_en;
                push_addr <= pend.push_addr;
            end
            else
            begin
                done    <= 1'b0;
                wr_en   <= 1'b0;
                status_flags_register_we <= 1'b0;
                pc_we   <= 1'b0;
                push_en <= 1'b0;
            end
        end
    end

    property p_add_sum;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_ADD && !req.use_imm) |=>
            (done && wr_en &&
             wr_data == 8'($past(req.rd_val) + $past(req.rr_val)));
    endproperty
    a_add_sum: assert property (p_add_sum)
        else $error("add result wrong");

    property p_adc_sum;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_ADC && !req.use_imm) |=>
            (wr_data == 8'($past(req.rd_val) + $past(req.rr_val) +
                           8'($past(req.status_flags_register[`FLAG_C]))));
    endproperty
    a_adc_sum: assert property (p_adc_sum)
        else $error("add with carry result wrong");

    property p_sub_borrow;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_SUB && !req.use_imm) |=>
            (wr_en && status_flags_register_out[`FLAG_C] ==
             ($past(req.rd_val) < $past(req.rr_val)));
    endproperty
    a_sub_borrow: assert property (p_sub_borrow)
        else $error("subtract borrow wrong");

    property p_logic_keep;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && (req.op == exec_pkg::OP_AND ||
                    req.op == exec_pkg::OP_OR ||
                    req.op == exec_pkg::OP_EOR)) |=>
            (status_flags_register_out[`FLAG_C] == $past(req.status_flags_register[`FLAG_C]) &&
             status_flags_register_out[`FLAG_H] == $past(req.status_flags_register[`FLAG_H]) &&
             !status_flags_register_out[`FLAG_V]);
    endproperty
    a_logic_keep: assert property (p_logic_keep)
        else $error("logic op touched carry or half carry");

    property p_clear_mask;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_CBR && req.use_imm) |=>
            (wr_data == ($past(req.rd_val) & ~$past(req.imm)));
    endproperty
    a_clear_mask: assert property (p_clear_mask)
        else $error("clear bits by mask wrong");

    property p_test_nowrite;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_TST) |=>
            (done && !wr_en && status_flags_register_we &&
             status_flags_register_out[`FLAG_Z] == ($past(req.rd_val) == 8'h00));
    endproperty
    a_test_nowrite: assert property (p_test_nowrite)
        else $error("self test wrote or flagged wrong");

    property p_ptr_jump;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_JUMP_VIA_POINTER) |=>
            (!done ##1 (done && !status_flags_register_we &&
             pc_next == {6'h00, $past(req.z_ptr, 2)}));
    endproperty
    a_ptr_jump: assert property (p_ptr_jump)
        else $error("pointer jump wrong");

    property p_call_push;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_RELATIVE_CALL) |=>
            !done ##[1:3] (done && push_en);
    endproperty
    a_call_push: assert property (p_call_push)
        else $error("relative call did not push in time");

    property p_branch_fall;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_BR_CLR &&
         req.status_flags_register[req.bit_sel]) |=>
            (done && pc_next == $past(req.pc) + `PC_STEP);
    endproperty
    a_branch_fall: assert property (p_branch_fall)
        else $error("untaken branch not one cycle");

    property p_signed_less;
        @(posedge ref_clk) disable iff (!nrst || !ce)
        (accept && req.op == exec_pkg::OP_BR_SLT &&
         (req.status_flags_register[`FLAG_N] ^ req.status_flags_register[`FLAG_V])) |=>
            !done ##1 done;
    endproperty
    a_signed_less: assert property (p_signed_less)
        else $error("signed less branch not taken");

    property p_sign_flag;
        @(posedge ref_clk) disable iff (!nrst)
        status_flags_register_we |-> status_flags_register_out[`FLAG_S] ==
            (status_flags_register_out[`FLAG_N] ^ status_flags_register_out[`FLAG_V]);
    endproperty
    a_sign_flag: assert property (p_sign_flag)
        else $error("sign flag not N xor V");
endmodule

/* verif/fetch_model.sv */
// fetch stage model that hands one decoded request at a time to the block
`timescale 1ns/100ps
module fetch_model
(
    input  wire logic           ref_clk,    // core clock
    input  wire logic           ready,      // block can take a request
    output logic                req_valid,  // request offered
    output exec_pkg::exec_req_t req         // request fields
);
    initial
    begin
        req_valid = 1'b0;
        req       = '0;
    end

    // held from a falling edge through the taking edge, then scrambled
    // at the next falling edge so nothing can lean on stale fields
    task automatic issue(input exec_pkg::exec_req_t r);
        @(negedge ref_clk);
        req_valid = 1'b1;
        req       = r;
        while (ready !== 1'b1)
            @(negedge ref_clk);
        @(posedge ref_clk);
        @(negedge ref_clk);
        req_valid = 1'b0;
        req       = ~r;
    endtask
endmodule

/* verif/arith_logic_branch_exec_tb.sv */
// self-checking bench for the execution block
`timescale 1ns/100ps
`include "exec_cfg.svh"
module arith_logic_branch_exec_tb;
    logic                ref_clk = 1'b0;
    logic                nrst    = 1'b0;
    logic                req_valid, ready, done, wr_en, status_flags_register_we;
    logic                pc_we, push_en;
    logic [7:0]          wr_data, status_flags_register_out;
    logic [21:0]         pc_next, push_addr;
    exec_pkg::exec_req_t req, r;
    int                  error_cnt = 0;
    int                  cmp_count = 0;
    int                  seed      = 32'hc7bee0e6;
    int                  n;
    logic [11:0]         a;
    logic [24:0]         f;

    always #12.5 ref_clk = ~ref_clk;

    arith_logic_branch_exec DUT (.ref_clk(ref_clk), .nrst(nrst), .ce(1'b1),
        .req_valid(req_valid), .req(req), .ready(ready), .done(done),
        .wr_en(wr_en), .wr_data(wr_data), .status_flags_register_we(status_flags_register_we),
        .status_flags_register_out(status_flags_register_out), .pc_we(pc_we), .pc_next(pc_next),
        .push_en(push_en), .push_addr(push_addr));
    fetch_model u_fetch (.ref_clk(ref_clk), .ready(ready),
        .req_valid(req_valid), .req(req));

    // {wr_en, status_flags_register_we, z, c, result}
    function automatic logic [11:0] exp_alu(exec_pkg::exec_req_t q);
        logic [7:0] b;
        logic [8:0] s;
        logic       c;
        b = q.use_imm ? q.imm : q.rr_val;
        c = q.status_flags_register[0];
        case (q.op)
            5'h00: s = {1'b0, q.rd_val} + b;
            5'h01: s = {1'b0, q.rd_val} + b + c;
            5'h02, 5'h09: s = {1'b0, q.rd_val} - b;
            5'h03, 5'h0A: s = {1'b0, q.rd_val} - b - c;
            5'h04: s = {c, q.rd_val & b};
            5'h05: s = {c, q.rd_val | b};
            5'h06: s = {c, q.rd_val ^ b};
            5'h07: s = {c, q.rd_val & (8'hFF - b)};
            default: s = {c, q.rd_val};
        endcase
        // chained compare keeps zero only if it was already set
        return {q.op <= 5'h07, q.op <= 5'h0A, s[7:0] == 8'h00 &&
            !((q.op == 5'h03 || q.op == 5'h0A) && !q.status_flags_register[1]), s};
    endfunction

    // {cycles, next program counter}
    function automatic logic [24:0] exp_flow(exec_pkg::exec_req_t q);
        logic        t;
        logic [2:0]  c;
        logic [21:0] k;
        k = q.pc + {{10{q.offset[11]}}, q.offset} + 22'h000001;
        case (q.op)
            5'h0B: t = q.rd_val == q.rr_val;
            5'h0C: t = !q.rr_val[q.bit_sel];
            5'h0D: t = q.rr_val[q.bit_sel];
            5'h0E: t = !q.io_val[q.bit_sel];
            5'h0F: t = q.io_val[q.bit_sel];
            5'h10: t = q.status_flags_register[q.bit_sel];
            5'h11: t = !q.status_flags_register[q.bit_sel];
            5'h12: t = !(q.status_flags_register[2] ^ q.status_flags_register[3]);
            default: t = q.status_flags_register[2] ^ q.status_flags_register[3];
        endcase
        c = t ? (q.next_two_word ? 3'h3 : 3'h2) : 3'h1;
        case (q.op)
            5'h0B, 5'h0C, 5'h0D, 5'h0E, 5'h0F: return {c, q.pc + 22'(c)};
            5'h10, 5'h11, 5'h12, 5'h13:
                return t ? {3'h2, k} : {3'h1, q.pc + 22'h000001};
            5'h14: return {3'h2, k};
            5'h15: return {3'(`CYC_CALL_DEF), k};
            5'h16: return {3'h2, 6'h00, q.z_ptr};
            5'h17: return {3'(`CYC_CALL_DEF), 6'h00, q.z_ptr};
            default: return {3'h1, q.pc + 22'h000001};
        endcase
    endfunction

    task automatic chk(input logic [21:0] got, input logic [21:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("MISMATCH t=%0t op %h got %h exp %h", $time, r.op,
                got, exp);
        end
    endtask

    task automatic print_verdict;
        if (error_cnt == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    initial
    begin
        #500000;
        error_cnt++;
        print_verdict();
    end

    initial
    begin
        repeat (12) @(negedge ref_clk);
        nrst = 1'b1;
        for (int i = 0; i < 400; i++)
        begin
            r = 100'({$random(seed), $random(seed), $random(seed),
                $random(seed)});
            // first pass walks every operation once
            r.op = exec_pkg::exec_op_t'(5'(i < 24 ? i :
                $unsigned($random(seed)) % 24));
            if (i == 0)
            begin
                r.rd_val  = 8'hFF;
                r.rr_val  = 8'h01;
                r.use_imm = 1'b0;
            end
            if (i == 16)
                r.offset = 12'h800;
            u_fetch.issue(r);
            // issue returns on the falling edge after the taking edge
            n = 1;
            while (done !== 1'b1 && n < 8)
            begin
                @(negedge ref_clk);
                n++;
            end
            a = exp_alu(r);
            f = exp_flow(r);
            chk(wr_en, a[11]);
            chk(status_flags_register_we, a[10]);
            if (a[11])
                chk(wr_data, a[7:0]);
            if (a[10])
            begin
                chk(status_flags_register_out[1:0], a[9:8]);
                chk(status_flags_register_out[2], a[7]);
                chk(status_flags_register_out[4], status_flags_register_out[2] ^ status_flags_register_out[3]);
            end
            if (r.op >= 5'h04 && r.op <= 5'h08)
                chk(status_flags_register_out[3], 1'b0);
            chk(pc_we, 1'b1);
            chk(pc_next, f[21:0]);
            chk(22'(n), 22'(f[24:22]));
            chk(push_en, r.op == 5'h15 || r.op == 5'h17);
            if (push_en === 1'b1)
                chk(push_addr, r.pc + 22'h000001);
        end
        print_verdict();
    end
endmodule
